/* include/tamc_params.svh */
// Offsets, field positions, reset values and timing counts of the trigger/arm control.
`ifndef TAMC_PARAMS_SVH
`define TAMC_PARAMS_SVH

// Register byte offsets.
`define TAMC_REG_CTRL       8'h00
`define TAMC_REG_CMD        8'h04
`define TAMC_REG_TRIG_PER   8'h08
`define TAMC_REG_DELAY0     8'h0c
`define TAMC_REG_STATUS     8'h1c

// Control register fields.
`define TAMC_CTRL_CONT      0
`define TAMC_CTRL_GATE      1
`define TAMC_CTRL_EXTARM    2
`define TAMC_CTRL_ENBLK     3
`define TAMC_CTRL_TRBLK     4
`define TAMC_CTRL_SYNC      5
`define TAMC_CTRL_TSLOPE    6
`define TAMC_CTRL_ESLOPE    8
`define TAMC_CTRL_TSRC      10
`define TAMC_CTRL_ENSRC     12
`define TAMC_CTRL_RST       13'h0000

// Command register bits, each a one-shot action on write.
`define TAMC_CMD_START      0
`define TAMC_CMD_HALT       1
`define TAMC_CMD_TRIG       2
`define TAMC_CMD_ENABLE     3
`define TAMC_CMD_ARM        4
`define TAMC_CMD_GOPEN      5
`define TAMC_CMD_GCLOSE     6

// Internal generator period in clock cycles; zero stops the generator.
`define TAMC_TRIG_PER_RST   32'h0000_0000

// Sample delay range and reset value.
`define TAMC_DELAY_MAX      7'h5f
`define TAMC_DELAY_RST      7'h00

// Synchronous input operation: events are released on a grid of this many cycles.
`define TAMC_SYNC_PERIOD_NS 80
`define TAMC_CLK_PERIOD_NS  10
`define TAMC_SYNC_CYCLES    (`TAMC_SYNC_PERIOD_NS / `TAMC_CLK_PERIOD_NS)

`endif

/* include/tamc_pkg.sv */
// Types shared by the trigger/arm control files.
`default_nettype none
package tamc_pkg;
  typedef enum logic [1:0] {
    TAMC_MODE_TRIGGERED  = 2'b00,
    TAMC_MODE_GATED      = 2'b01,
    TAMC_MODE_CONTINUOUS = 2'b10
  } tamc_mode_e;

  typedef enum logic [1:0] {
    TAMC_SLOPE_RISE = 2'b00,
    TAMC_SLOPE_FALL = 2'b01,
    TAMC_SLOPE_BOTH = 2'b10
  } tamc_slope_e;

  typedef enum logic [1:0] {
    TAMC_SRC_TRIGGER  = 2'b00,
    TAMC_SRC_EVENT    = 2'b01,
    TAMC_SRC_INTERNAL = 2'b10
  } tamc_src_e;

  typedef enum logic [1:0] {
    TAMC_ST_IDLE     = 2'b00,
    TAMC_ST_WAIT_ARM = 2'b01,
    TAMC_ST_EXTERNAL_ARMING    = 2'b10,
    TAMC_ST_RUN      = 2'b11
  } tamc_state_e;
endpackage
`default_nettype wire

/* rtl/tamc_delay_mem.sv */
// Circular sample memory of one channel with a registered read port.
`default_nettype none
module tamc_delay_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic             sys_clk_in,
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic [AW-1:0]    rd_addr_in,
  output var  logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Write and registered read; the two addresses never coincide in use.
  always_ff @(posedge sys_clk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule
`default_nettype wire

/* rtl/tamc_top.sv */
// Trigger, arming and run mode control with per-channel sample delay.
//
// Behaviour
// - Each channel delays its samples by 0 to 95 sample clock periods.
// - Continuous run setting on gives continuous mode, gating setting ignored.
// - Continuous off: gating off gives triggered mode, gating on gives gated.
// - Start command starts all four channels together.
// - Arming is either self-arming or waits for an explicit arm command.
// - Trigger input edge detector responds to rising, falling or both edges.
// - Trigger source is trigger input, event input or internal generator.
// - Internal generator makes periodic triggers at a programmable rate.
// - Trigger and event inputs share asynchronous or synchronous edge handling.
// - Event input edge detector responds to rising, falling or both edges.
// - Enable event hardware source is trigger input or event input.
// - Enable hardware block set: enable events only from software command.
// - Enable hardware unblocked: software command or selected input both count.
// - Trigger hardware block set: triggers only from software command.
// - Trigger unblocked: software command or the source selected by trig_src (trigger input, event input or internal generator) both count.
// - In gated mode software gate command opens and closes the gate.
// - Halt command stops generation on all channels.
//
// Local design decisions: strobed register access and the address map.
`include "tamc_params.svh"
`default_nettype none
module tamc_top #(
  parameter int NCH    = 4,
  parameter int SWIDTH = 8,
  parameter int DEPTH  = 128,
  parameter int AW     = 7
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic [7:0]             reg_addr_in,
  input  wire logic [31:0]            reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output var  logic [31:0]            reg_rdata_out,
  input  wire logic                   trig_pin_in,
  input  wire logic                   event_pin_in,
  input  wire logic [NCH*SWIDTH-1:0]  sample_in,
  output var  logic [NCH*SWIDTH-1:0]  sample_out,
  output var  logic [NCH-1:0]         run_out,
  output var  logic                   trigger_event_out,
  output var  logic                   enable_event_out,
  output var  tamc_pkg::tamc_mode_e   mode_out
);
  import tamc_pkg::*;

  // Decodes an edge of a synchronised pin according to the slope setting.
  function automatic logic edge_hit(input logic cur, input logic prev,
                                    input logic [1:0] slope);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (slope)
      TAMC_SLOPE_RISE: edge_hit = rise;
      TAMC_SLOPE_FALL: edge_hit = fall;
      TAMC_SLOPE_BOTH: edge_hit = rise | fall;
      default:         edge_hit = 1'b0;
    endcase
  endfunction

  // Software settings.
  logic [12:0]      ctrl;
  logic [31:0]      trig_period;
  logic [6:0]       delay [NCH];
  logic             wr_ctrl;
  logic             wr_cmd;
  logic             wr_per;
  logic [6:0]       wdata_delay;

  // Command pulses, one cycle after the write.
  logic             cmd_start;
  logic             cmd_halt;
  logic             cmd_trig;
  logic             cmd_enable;
  logic             cmd_arm;
  logic             cmd_gopen;
  logic             cmd_gclose;

  // Field views of the control word.
  logic             cont_run_select;
  logic             gate_select;
  logic             external_arming;
  logic             enable_block;
  logic             trigger_block;
  logic             sync_oper;
  logic [1:0]       trig_slope;
  logic [1:0]       event_slope;
  logic [1:0]       trig_src;
  logic             enable_src;

  assign cont_run_select = ctrl[`TAMC_CTRL_CONT];
  assign gate_select     = ctrl[`TAMC_CTRL_GATE];
  assign external_arming = ctrl[`TAMC_CTRL_EXTARM];
  assign enable_block    = ctrl[`TAMC_CTRL_ENBLK];
  assign trigger_block   = ctrl[`TAMC_CTRL_TRBLK];
  assign sync_oper       = ctrl[`TAMC_CTRL_SYNC];
  assign trig_slope      = ctrl[`TAMC_CTRL_TSLOPE+1:`TAMC_CTRL_TSLOPE];
  assign event_slope     = ctrl[`TAMC_CTRL_ESLOPE+1:`TAMC_CTRL_ESLOPE];
  assign trig_src        = ctrl[`TAMC_CTRL_TSRC+1:`TAMC_CTRL_TSRC];
  assign enable_src      = ctrl[`TAMC_CTRL_ENSRC];

  // Register write decode.
  assign wr_ctrl = reg_wr_in && (reg_addr_in == `TAMC_REG_CTRL);
  assign wr_cmd  = reg_wr_in && (reg_addr_in == `TAMC_REG_CMD);
  assign wr_per  = reg_wr_in && (reg_addr_in == `TAMC_REG_TRIG_PER);

  // delay clamp: values above 95 are held at 95 so the read never overtakes the write.
  assign wdata_delay = (reg_wdata_in[6:0] > `TAMC_DELAY_MAX) ? `TAMC_DELAY_MAX
                                                             : reg_wdata_in[6:0];

  // Control and period registers.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      ctrl        <= `TAMC_CTRL_RST;
      trig_period <= `TAMC_TRIG_PER_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl <= reg_wdata_in[12:0];
      end
      if (wr_per)
      begin
        trig_period <= reg_wdata_in;
      end
    end
  end

  // Per-channel delay registers, one word each.
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_dly
      always_ff @(posedge sys_clk_in)
      begin
        if (sys_rst_in)
        begin
          delay[g] <= `TAMC_DELAY_RST;
        end
        else if (reg_wr_in && (reg_addr_in == 8'(`TAMC_REG_DELAY0 + 4 * g)))
        begin
          delay[g] <= wdata_delay;
        end
      end
    end
  endgenerate

  // Command pulses; a write with no bit set does nothing.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      cmd_start  <= 1'b0;
      cmd_halt   <= 1'b0;
      cmd_trig   <= 1'b0;
      cmd_enable <= 1'b0;
      cmd_arm    <= 1'b0;
      cmd_gopen  <= 1'b0;
      cmd_gclose <= 1'b0;
    end
    else
    begin
      cmd_start  <= wr_cmd & reg_wdata_in[`TAMC_CMD_START];
      cmd_halt   <= wr_cmd & reg_wdata_in[`TAMC_CMD_HALT];
      cmd_trig   <= wr_cmd & reg_wdata_in[`TAMC_CMD_TRIG];
      cmd_enable <= wr_cmd & reg_wdata_in[`TAMC_CMD_ENABLE];
      cmd_arm    <= wr_cmd & reg_wdata_in[`TAMC_CMD_ARM];
      cmd_gopen  <= wr_cmd & reg_wdata_in[`TAMC_CMD_GOPEN];
      cmd_gclose <= wr_cmd & reg_wdata_in[`TAMC_CMD_GCLOSE];
    end
  end

  // pin synchronisers: two flops, then a third stage for edge history.
  logic [1:0] trig_sync;
  logic [1:0] event_sync;
  logic       trig_prev;
  logic       event_prev;
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      trig_sync  <= 2'b00;
      event_sync <= 2'b00;
      trig_prev  <= 1'b0;
      event_prev <= 1'b0;
    end
    else
    begin
      trig_sync  <= {trig_sync[0], trig_pin_in};
      event_sync <= {event_sync[0], event_pin_in};
      trig_prev  <= trig_sync[1];
      event_prev <= event_sync[1];
    end
  end

  logic trig_edge;
  logic event_edge;
  assign trig_edge  = edge_hit(trig_sync[1], trig_prev, trig_slope);
  assign event_edge = edge_hit(event_sync[1], event_prev, event_slope);

  // Grid for synchronous operation.
  localparam int SYNC_N = (`TAMC_SYNC_CYCLES < 1) ? 1 : `TAMC_SYNC_CYCLES;
  logic [7:0] sync_cnt;
  logic       sync_tick;
  assign sync_tick = (sync_cnt == 8'(SYNC_N - 1));
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      sync_cnt <= 8'h00;
    end
    else
    begin
      sync_cnt <= sync_tick ? 8'h00 : sync_cnt + 8'h01;
    end
  end

  // shared operation: asynchronous passes edges at once, synchronous holds them for the grid.
  logic trig_pend;
  logic event_pend;
  logic trig_ev;
  logic event_ev;
  assign trig_ev  = sync_oper ? (sync_tick & (trig_pend | trig_edge)) : trig_edge;
  assign event_ev = sync_oper ? (sync_tick & (event_pend | event_edge)) : event_edge;
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in || !sync_oper)
    begin
      trig_pend  <= 1'b0;
      event_pend <= 1'b0;
    end
    else
    begin
      // A new edge in the release cycle is released with it, never lost.
      trig_pend  <= (trig_pend | trig_edge) & ~sync_tick;
      event_pend <= (event_pend | event_edge) & ~sync_tick;
    end
  end

  // internal generator: one pulse every trig_period cycles.
  logic [31:0] gen_cnt;
  logic        gen_ev;
  assign gen_ev = (trig_period != 32'h0) && (gen_cnt >= trig_period - 32'h1);
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in || wr_per || gen_ev)
    begin
      gen_cnt <= 32'h0;
    end
    else
    begin
      gen_cnt <= gen_cnt + 32'h1;
    end
  end

  logic hw_trig;
  always_comb
  begin
    case (trig_src)
      TAMC_SRC_TRIGGER:  hw_trig = trig_ev;
      TAMC_SRC_EVENT:    hw_trig = event_ev;
      TAMC_SRC_INTERNAL: hw_trig = gen_ev;
      default:           hw_trig = 1'b0;
    endcase
  end

  logic trig_any;
  logic enable_any;
  assign trig_any   = cmd_trig | (~trigger_block & hw_trig);
  assign enable_any = cmd_enable | (~enable_block & (enable_src ? event_ev : trig_ev));

  tamc_mode_e mode;
  assign mode = cont_run_select ? TAMC_MODE_CONTINUOUS
              : (gate_select ? TAMC_MODE_GATED : TAMC_MODE_TRIGGERED);

  // software gate; halt closes it so a restart begins shut.
  logic gate_open;
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in || cmd_halt)
    begin
      gate_open <= 1'b0;
    end
    else if (cmd_gopen)
    begin
      gate_open <= 1'b1;
    end
    else if (cmd_gclose)
    begin
      gate_open <= 1'b0;
    end
  end

  // Run state machine shared by all channels.
  tamc_state_e state;
  tamc_state_e next_state;
  always_comb
  begin
    next_state = state;
    case (state)
      TAMC_ST_IDLE:
      begin
        if (cmd_start)
        begin
          next_state = external_arming ? TAMC_ST_WAIT_ARM : TAMC_ST_EXTERNAL_ARMING;
        end
      end
      TAMC_ST_WAIT_ARM:
      begin
        if (cmd_arm)
        begin
          next_state = TAMC_ST_EXTERNAL_ARMING;
        end
      end
      TAMC_ST_EXTERNAL_ARMING:
      begin
        case (mode)
          TAMC_MODE_CONTINUOUS: next_state = TAMC_ST_RUN;
          TAMC_MODE_GATED:      next_state = gate_open ? TAMC_ST_RUN : TAMC_ST_EXTERNAL_ARMING;
          default:              next_state = trig_any ? TAMC_ST_RUN : TAMC_ST_EXTERNAL_ARMING;
        endcase
      end
      TAMC_ST_RUN:
      begin
        // closing the gate pauses output until it opens again.
        if (mode == TAMC_MODE_GATED && !gate_open)
        begin
          next_state = TAMC_ST_EXTERNAL_ARMING;
        end
      end
      default: next_state = TAMC_ST_IDLE;
    endcase
    if (cmd_halt)
    begin
      next_state = TAMC_ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state <= TAMC_ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Registered outputs; all channels share one run flag.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      run_out           <= '0;
      trigger_event_out <= 1'b0;
      enable_event_out  <= 1'b0;
      mode_out          <= TAMC_MODE_TRIGGERED;
    end
    else
    begin
      run_out           <= {NCH{next_state == TAMC_ST_RUN}};
      trigger_event_out <= trig_any;
      enable_event_out  <= enable_any;
      mode_out          <= mode;
    end
  end

  // delay lines: write pointer shared, read lags by delay plus one.
  logic [AW-1:0] wptr;
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      wptr <= '0;
    end
    else
    begin
      wptr <= wptr + AW'(1);
    end
  end

  generate
    for (g = 0; g < NCH; g++)
    begin : g_mem
      tamc_delay_mem #(
        .WIDTH (SWIDTH),
        .DEPTH (DEPTH),
        .AW    (AW)
      ) tamc_delay_mem_i (
        .sys_clk_in  (sys_clk_in),
        .wr_en_in    (1'b1),
        .wr_addr_in  (wptr),
        .wr_data_in  (sample_in[g*SWIDTH +: SWIDTH]),
        .rd_addr_in  (wptr - AW'(delay[g]) - AW'(1)),
        .rd_data_out (sample_out[g*SWIDTH +: SWIDTH])
      );
    end
  endgenerate

  // Read data stand one cycle after the read strobe; unmapped addresses read zero.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      reg_rdata_out <= 32'h0;
    end
    else if (reg_rd_in)
    begin
      reg_rdata_out <= 32'h0;
      case (reg_addr_in)
        `TAMC_REG_CTRL:     reg_rdata_out <= {19'h0, ctrl};
        `TAMC_REG_TRIG_PER: reg_rdata_out <= trig_period;
        `TAMC_REG_STATUS:   reg_rdata_out <= {27'h0, gate_open, mode, state};
        default:
        begin
          for (int i = 0; i < NCH; i++)
          begin
            if (reg_addr_in == 8'(`TAMC_REG_DELAY0 + 4 * i))
            begin
              reg_rdata_out <= {25'h0, delay[i]};
            end
          end
        end
      endcase
    end
    else
    begin
      reg_rdata_out <= 32'h0;
    end
  end
endmodule
`default_nettype wire

/* verif/tamc_top_props.sv */
// Checker of mode, run and event relations at the ports of the trigger/arm control.
`include "tamc_params.svh"
`default_nettype none
module tamc_top_props #(
  parameter int NCH = 4
) (
  input wire logic                 sys_clk_in,
  input wire logic                 sys_rst_in,
  input wire logic [7:0]           reg_addr_in,
  input wire logic [31:0]          reg_wdata_in,
  input wire logic                 reg_wr_in,
  input wire logic [NCH-1:0]       run_out,
  input wire logic                 trigger_event_out,
  input wire logic                 enable_event_out,
  input wire tamc_pkg::tamc_mode_e mode_out
);
  import tamc_pkg::*;
  logic        wr_ctrl;
  logic        wr_cmd;
  logic [12:0] ctrl;
  logic [3:0]  trig_age;
  logic [3:0]  en_age;
  logic [1:0]  exp_mode;
  assign wr_ctrl = reg_wr_in && (reg_addr_in == `TAMC_REG_CTRL);
  assign wr_cmd = reg_wr_in && (reg_addr_in == `TAMC_REG_CMD);
  // Shadow of the control word, so event checks know which inputs are blocked.
  always_ff @(posedge sys_clk_in)
    if (sys_rst_in)
      ctrl <= 13'h0000;
    else if (wr_ctrl)
      ctrl <= reg_wdata_in[12:0];
  // Expected mode from the shadow settings, one register stage behind like the output.
  always_ff @(posedge sys_clk_in)
    if (sys_rst_in)
      exp_mode <= 2'h0;
    else
      exp_mode <= ctrl[`TAMC_CTRL_CONT] ? 2'h2 : {1'b0, ctrl[`TAMC_CTRL_GATE]};
  // Cycles since the last software trigger and enable; saturating avoids wrap-around.
  always_ff @(posedge sys_clk_in)
    if (sys_rst_in || (wr_cmd && reg_wdata_in[`TAMC_CMD_TRIG]))
      trig_age <= sys_rst_in ? 4'hf : 4'h0;
    else if (trig_age != 4'hf)
      trig_age <= trig_age + 4'h1;
  always_ff @(posedge sys_clk_in)
    if (sys_rst_in || (wr_cmd && reg_wdata_in[`TAMC_CMD_ENABLE]))
      en_age <= sys_rst_in ? 4'hf : 4'h0;
    else if (en_age != 4'hf)
      en_age <= en_age + 4'h1;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_CONT_MODE: assert property (
    wr_ctrl && reg_wdata_in[0] |-> ##3 mode_out == TAMC_MODE_CONTINUOUS)
    else $error("continuous setting did not give continuous mode");
  AST_GATED_MODE: assert property (
    wr_ctrl && reg_wdata_in[1:0] == 2'h2 |-> ##3 mode_out == TAMC_MODE_GATED)
    else $error("gating setting did not give gated mode");
  AST_TRIG_MODE: assert property (
    wr_ctrl && reg_wdata_in[1:0] == 2'h0 |-> ##3 mode_out == TAMC_MODE_TRIGGERED)
    else $error("both settings off did not give triggered mode");
  AST_MODE_LEGAL: assert property (
    mode_out == exp_mode)
    else $error("mode output disagrees with the settings");
  AST_RUN_ALL: assert property (
    $changed(run_out) |-> run_out == '0 || run_out == '1)
    else $error("channels not running together");
  AST_HALT: assert property (
    wr_cmd && reg_wdata_in[`TAMC_CMD_HALT] |-> ##3 run_out == '0)
    else $error("halt did not stop the channels");
  AST_TRIG_BLOCK: assert property (
    trigger_event_out && ctrl[`TAMC_CTRL_TRBLK] |-> trig_age == 4'h1)
    else $error("trigger pulse without software trigger while blocked");
  AST_EN_BLOCK: assert property (
    enable_event_out && ctrl[`TAMC_CTRL_ENBLK] |-> en_age == 4'h1)
    else $error("enable pulse without software enable while blocked");
endmodule
bind tamc_top tamc_top_props #(.NCH(NCH)) tamc_top_props_i (
  .sys_clk_in        (sys_clk_in),
  .sys_rst_in        (sys_rst_in),
  .reg_addr_in       (reg_addr_in),
  .reg_wdata_in      (reg_wdata_in),
  .reg_wr_in         (reg_wr_in),
  .run_out           (run_out),
  .trigger_event_out (trigger_event_out),
  .enable_event_out  (enable_event_out),
  .mode_out          (mode_out)
);
`default_nettype wire

/* verif/tamc_pin_src.sv */
// Model of the external trigger and event sources that drive the two pins.
`default_nettype none
module tamc_pin_src (
  input  wire logic sys_clk_in,
  input  wire logic trig_flip_in,
  input  wire logic evt_flip_in,
  output var  logic trig_pin_out,
  output var  logic event_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    trig_pin_out = 1'b0;
    event_pin_out = 1'b0;
  end
  // Pins move 3 ns after the edge, so they are truly out of step with the sampling.
  always @(posedge sys_clk_in)
  begin
    if (trig_flip_in)
      trig_pin_out <= #3 ~trig_pin_out;
    if (evt_flip_in)
      event_pin_out <= #3 ~event_pin_out;
  end
endmodule
`default_nettype wire

/* verif/tamc_bench.sv */
// Self-checking bench for the trigger/arm control: register tasks and scenario sequences.
`include "tamc_params.svh"
`default_nettype none
module tamc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tamc_pkg::*;
  logic        sys_clk_in, sys_rst_in, reg_wr_in, reg_rd_in, tf, ef, tpin, epin;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, sample_in, sample_out, m;
  logic [3:0]  run_out;
  logic        trigger_event_out, enable_event_out;
  tamc_mode_e  mode_out;
  int          num_errors, checked, cyc, tcnt, ecnt, tlast, n, r;
  tamc_top tamc_top_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .trig_pin_in(tpin),
    .event_pin_in(epin), .sample_in(sample_in), .sample_out(sample_out),
    .run_out(run_out), .trigger_event_out(trigger_event_out),
    .enable_event_out(enable_event_out), .mode_out(mode_out));
  tamc_pin_src tamc_pin_src_i (.sys_clk_in(sys_clk_in), .trig_flip_in(tf),
    .evt_flip_in(ef), .trig_pin_out(tpin), .event_pin_out(epin));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
  endtask
  // A gap cycle after each strobe keeps one assignment per signal per time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    tick(1);
    reg_wr_in <= 1'b0;
    tick(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    tick(1);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
    tick(1);
  endtask
  task automatic cmd(input int b);
    wr(`TAMC_REG_CMD, 32'h1 << b);
  endtask
  task automatic restart(input logic [31:0] c);
    wr(`TAMC_REG_CTRL, c);
    cmd(`TAMC_CMD_HALT);
    cmd(`TAMC_CMD_START);
    tick(4);
  endtask
  task automatic flip(input int p);
    if (p == 0)
      tf <= 1'b1;
    else
      ef <= 1'b1;
    tick(1);
    tf <= 1'b0;
    ef <= 1'b0;
    tick(11);
  endtask
  // Event counters, ramp samples and the hang guard share one clocked process.
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    sample_in <= {cyc[7:0] + 8'h3, cyc[7:0] + 8'h2, cyc[7:0] + 8'h1, cyc[7:0]};
    if (trigger_event_out === 1'b1)
    begin
      tcnt <= tcnt + 1;
      tlast <= cyc;
    end
    if (enable_event_out === 1'b1)
      ecnt <= ecnt + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    {sys_rst_in, reg_wr_in, reg_rd_in, tf, ef} = 5'h10;
    {reg_addr_in, reg_wdata_in, sample_in} = '0;
    {num_errors, checked, cyc, tcnt, ecnt, tlast} = '0;
    tick(8);
    sys_rst_in <= 1'b0;
    tick(1);
    chk({30'h0, mode_out}, 32'h0);
    rdc(`TAMC_REG_STATUS, 32'h0);
    rdc(8'h40, 32'h0);
    for (int v = 0; v < 4; v++)
    begin
      wr(`TAMC_REG_CTRL, v);
      tick(3);
      m = v[0] ? 32'h2 : (v[1] ? 32'h1 : 32'h0);
      chk({30'h0, mode_out}, m);
      rdc(`TAMC_REG_STATUS, m << 2);
    end
    $display("mode table done");
    for (int c = 0; c < 4; c++)
      wr(`TAMC_REG_DELAY0 + 8'(4 * c), 40 * c);
    tick(110);
    #1;
    for (int c = 0; c < 4; c++)
    begin
      m = (c == 3) ? 32'd95 : 40 * c;
      chk(sample_out[c*8+:8], 8'(sample_in[c*8+:8] - 8'(2 + m)));
    end
    tick(1);
    rdc(`TAMC_REG_DELAY0 + 8'hc, 32'h5f);
    $display("sample delay done");
    restart(32'h1);
    chk(run_out, 4'hf);
    cmd(`TAMC_CMD_HALT);
    tick(3);
    chk(run_out, 4'h0);
    restart(32'h5);
    chk(run_out, 4'h0);
    rdc(`TAMC_REG_STATUS, 32'h9);
    cmd(`TAMC_CMD_ARM);
    tick(4);
    chk(run_out, 4'hf);
    restart(32'h2);
    cmd(`TAMC_CMD_GOPEN);
    tick(4);
    chk(run_out, 4'hf);
    rdc(`TAMC_REG_STATUS, 32'h17);
    cmd(`TAMC_CMD_GCLOSE);
    tick(4);
    chk(run_out, 4'h0);
    $display("run control done");
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 3; s++)
      begin
        restart((s << 6) | (s << 8) | (p << 10));
        n = tcnt;
        flip(p);
        flip(p);
        chk(tcnt - n, (s == 2) ? 2 : 1);
      end
    restart(32'h10);
    n = tcnt;
    flip(0);
    flip(0);
    chk(tcnt - n, 0);
    cmd(`TAMC_CMD_TRIG);
    tick(4);
    chk(tcnt - n, 1);
    restart(32'h800);
    wr(`TAMC_REG_TRIG_PER, 32'ha);
    rdc(`TAMC_REG_TRIG_PER, 32'ha);
    n = tcnt;
    tick(50);
    chk(tcnt - n, 5);
    wr(`TAMC_REG_TRIG_PER, 32'h0);
    $display("trigger sources done");
    restart(32'h1280);
    n = ecnt;
    flip(1);
    chk(ecnt - n, 1);
    flip(0);
    chk(ecnt - n, 1);
    cmd(`TAMC_CMD_ENABLE);
    tick(4);
    chk(ecnt - n, 2);
    wr(`TAMC_REG_CTRL, 32'h1288);
    flip(1);
    chk(ecnt - n, 2);
    cmd(`TAMC_CMD_ENABLE);
    tick(4);
    chk(ecnt - n, 3);
    $display("enable sources done");
    restart(32'h2a0);
    n = tcnt;
    flip(0);
    tick(3);
    r = tlast % 8;
    flip(0);
    tick(3);
    chk(tcnt - n, 2);
    chk(tlast % 8, r);
    $display("synchronous operation done");
    conclude();
  end
endmodule
`default_nettype wire
